// >>> csr_pkg.sv
// package: address map, field layout and reset values of the cpu control space
package csr_pkg;
    localparam logic [6:0] CSR_SPACE_LO     = 7'h74; // first control address
    localparam logic [6:0] CSR_SPACE_HI     = 7'h7f; // last control address
    localparam logic [6:0] CSR_ADDR_NIB3    = 7'h74; // most significant nibble
    localparam logic [6:0] CSR_ADDR_NIB2    = 7'h75;
    localparam logic [6:0] CSR_ADDR_NIB1    = 7'h76;
    localparam logic [6:0] CSR_ADDR_NIB0    = 7'h77; // least significant nibble
    localparam logic [6:0] CSR_WINDOW       = 7'h78; // window nibble
    localparam int         CSR_AR_FULL_W    = 16;    // printed register width
    localparam int         CSR_AR_EFF_W     = 11;    // default effective width
    localparam int         CSR_NIB_W        = 4;     // nibble width
    localparam int         CSR_STK_IDX_W    = 3;     // stack index width
    localparam int         CSR_FILE_ADDR_W  = 7;     // peripheral file address
    localparam logic [15:0] CSR_AR_RESET    = 16'h0000;
    localparam logic [3:0]  CSR_NIB_ZERO    = 4'h0;
    // datapath operations issued by the decoder
    typedef enum logic [3:0] {
        CSR_OP_NONE      = 4'b0000,
        CSR_OP_TBL_1ST   = 4'b0001, // table read, first cycle
        CSR_OP_TBL_2ND   = 4'b0010, // table read, second cycle
        CSR_OP_PUSH      = 4'b0011,
        CSR_OP_POP       = 4'b0100,
        CSR_OP_JUMP      = 4'b0101,
        CSR_OP_CALL      = 4'b0110,
        CSR_OP_INC       = 4'b0111,
        CSR_OP_BUF_LOAD  = 4'b1000, // table buffer into register
        CSR_OP_BUF_FETCH = 4'b1001, // register into table buffer
        CSR_OP_FILE_RD   = 4'b1010,
        CSR_OP_FILE_WR   = 4'b1011
    } csr_op_e;
endpackage

// >>> csr_nibble_mux.sv
// module: nibble read selection with fixed-zero masking of address register
`timescale 1ns/1ps
module csr_nibble_mux
    import csr_pkg::*;
#(
    parameter int EFF_W = CSR_AR_EFF_W
) (
    input  wire logic [15:0] ar_value,
    input  wire logic [3:0]  win_value,
    input  wire logic [6:0]  addr,
    output logic      [3:0]  rd_nibble,
    output logic             hit
);
    logic [15:0] masked; // high bits forced to zero

    // mask above effective width
    always_comb begin
        masked = ar_value & ((16'h0001 << EFF_W) - 16'h0001);
    end

    // decode control space for any bank
    always_comb begin
        hit = (addr >= CSR_SPACE_LO) && (addr <= CSR_SPACE_HI);
        unique case (addr)
            CSR_ADDR_NIB3: rd_nibble = masked[15:12];
            CSR_ADDR_NIB2: rd_nibble = masked[11:8];
            CSR_ADDR_NIB1: rd_nibble = masked[7:4];
            CSR_ADDR_NIB0: rd_nibble = masked[3:0];
            CSR_WINDOW:    rd_nibble = win_value;
            default:       rd_nibble = CSR_NIB_ZERO;
        endcase
    end
endmodule

// >>> csr_window.sv
// module: address register and window nibble of the cpu control space
`timescale 1ns/1ps

module csr_window
    import csr_pkg::*;
#(
    parameter int EFF_W = CSR_AR_EFF_W // 11 or 10 by variant
) (
    input  wire logic                       clk,
    input  wire logic                       reset,
    // data memory port, bank deliberately not an input
    input  wire logic [6:0]                 dm_addr,
    input  wire logic                       dm_wr,
    input  wire logic [3:0]                 dm_wdata,
    input  wire logic                       dm_rd,
    output logic      [3:0]                 dm_rdata,
    output logic                            dm_hit,
    // decoder operation strobe
    input  wire logic [3:0]                 op,
    input  wire logic [CSR_FILE_ADDR_W-1:0] op_file_addr,
    // stack side
    input  wire logic [CSR_STK_IDX_W-1:0]   stack_index,
    output logic                            stk_dec,
    output logic                            stk_inc,
    output logic                            stk_wr,
    output logic      [15:0]                stk_wdata,
    input  wire logic [15:0]                stk_rdata,
    // program counter / memory side
    output logic                            pc_load,
    output logic                            pc_call,
    output logic      [15:0]                pc_target,
    output logic                            rom_rd,
    output logic      [15:0]                rom_addr,
    input  wire logic [15:0]                rom_data,
    // table buffer
    input  wire logic [15:0]                table_buffer,
    output logic                            tbuf_wr,
    output logic      [15:0]                tbuf_wdata,
    // peripheral file
    output logic                            pf_rd,
    output logic                            pf_wr,
    output logic      [CSR_FILE_ADDR_W-1:0] pf_addr,
    output logic      [3:0]                 pf_wdata,
    input  wire logic [3:0]                 pf_rdata
);
    localparam logic [15:0] AR_MASK = (16'h0001 << EFF_W) - 16'h0001;

    csr_op_e      cur_op;      // decoded operation
    logic [15:0]  ar_q;        // address register
    logic [15:0]  ar_d;
    logic [3:0]   win_q;       // window nibble, no reset
    logic [3:0]   win_d;
    logic         pf_rd_q;     // file read issued last cycle
    logic         pf_rd_d;
    logic         tbl_q;       // table read second cycle pending fetch
    logic         tbl_d;
    logic [3:0]   rd_nib;      // combinational read nibble
    logic         hit;         // control space decode

    // output registers
    logic [3:0]   dm_rdata_q, dm_rdata_d;
    logic         dm_hit_q, dm_hit_d;
    logic         stk_dec_q, stk_dec_d;
    logic         stk_inc_q, stk_inc_d;
    logic         stk_wr_q, stk_wr_d;
    logic [15:0]  stk_wdata_q, stk_wdata_d;
    logic         pc_load_q, pc_load_d;
    logic         pc_call_q, pc_call_d;
    logic [15:0]  pc_target_q, pc_target_d;
    logic         rom_rd_q, rom_rd_d;
    logic [15:0]  rom_addr_q, rom_addr_d;
    logic         tbuf_wr_q, tbuf_wr_d;
    logic [15:0]  tbuf_wdata_q, tbuf_wdata_d;
    logic         pf_wr_q, pf_wr_d;
    logic [CSR_FILE_ADDR_W-1:0] pf_addr_q, pf_addr_d;
    logic [3:0]   pf_wdata_q, pf_wdata_d;

    assign cur_op = csr_op_e'(op);

    // read selection shared with the decode
    csr_nibble_mux #(
        .EFF_W     (EFF_W)
    ) u_mux (
        .ar_value  (ar_q),
        .win_value (win_q),
        .addr      (dm_addr),
        .rd_nibble (rd_nib),
        .hit       (hit)
    );

    // next state of the address register
    always_comb begin
        ar_d = ar_q;
        if (dm_wr) begin
            unique case (dm_addr)
                CSR_ADDR_NIB3: ar_d[15:12] = dm_wdata;
                CSR_ADDR_NIB2: ar_d[11:8]  = dm_wdata;
                CSR_ADDR_NIB1: ar_d[7:4]   = dm_wdata;
                CSR_ADDR_NIB0: ar_d[3:0]   = dm_wdata;
                default:       ar_d        = ar_q;
            endcase
        end
        unique case (cur_op)
            CSR_OP_POP:      ar_d = stk_rdata;
            CSR_OP_INC:      ar_d = ar_q + 16'h0001;
            CSR_OP_BUF_LOAD: ar_d = table_buffer;
            default:         ;
        endcase
        ar_d = ar_d & AR_MASK;
    end

    // address register, cleared by reset
    always_ff @(posedge clk) begin
        if (reset) begin
            ar_q <= CSR_AR_RESET;
        end else begin
            ar_q <= ar_d;
        end
    end

    // next state of the window nibble
    always_comb begin
        win_d = win_q;
        if (dm_wr && dm_addr == CSR_WINDOW) begin
            win_d = dm_wdata;
        end
        if (pf_rd_q) begin
            win_d = pf_rdata;
        end
    end

    // flags for operations answered on the second edge
    always_comb begin
        pf_rd_d = (cur_op == CSR_OP_FILE_RD);
        tbl_d   = (cur_op == CSR_OP_TBL_1ST);
    end

    // flags cleared by reset so no stale fetch follows it
    always_ff @(posedge clk) begin
        if (reset) begin
            pf_rd_q <= 1'b0;
            tbl_q   <= 1'b0;
        end else begin
            pf_rd_q <= pf_rd_d;
            tbl_q   <= tbl_d;
        end
    end

    // read answer and decode flag, one cycle after the access
    always_comb begin
        dm_rdata_d = CSR_NIB_ZERO;                // idle cycles read zero
        if (dm_rd) begin
            dm_rdata_d = rd_nib;
        end
        dm_hit_d   = hit;
    end

    // data memory answer registers
    always_ff @(posedge clk) begin
        if (reset) begin
            dm_rdata_q <= CSR_NIB_ZERO;
            dm_hit_q   <= 1'b0;
        end else begin
            dm_rdata_q <= dm_rdata_d;
            dm_hit_q   <= dm_hit_d;
        end
    end

    // stack strobes; push lowers the index before storing
    always_comb begin
        stk_dec_d   = 1'b0;
        stk_inc_d   = 1'b0;
        stk_wr_d    = 1'b0;
        stk_wdata_d = stk_wdata_q;                // data holds between pushes
        // one operation per cycle reaches the stack
        unique case (cur_op)
            CSR_OP_TBL_1ST: begin
                stk_dec_d = 1'b1;                 // borrow a level
            end
            CSR_OP_TBL_2ND: begin
                stk_inc_d = 1'b1;                 // give the level back
            end
            CSR_OP_PUSH: begin
                stk_dec_d   = 1'b1;
                stk_wr_d    = 1'b1;
                stk_wdata_d = ar_q & AR_MASK;
            end
            CSR_OP_POP: begin
                stk_inc_d = 1'b1;
            end
            CSR_OP_CALL: begin
                stk_dec_d = 1'b1;                 // room for return address
            end
            default: ;
        endcase
    end

    // stack strobe registers
    always_ff @(posedge clk) begin
        if (reset) begin
            stk_dec_q   <= 1'b0;
            stk_inc_q   <= 1'b0;
            stk_wr_q    <= 1'b0;
            stk_wdata_q <= CSR_AR_RESET;
        end else begin
            stk_dec_q   <= stk_dec_d;
            stk_inc_q   <= stk_inc_d;
            stk_wr_q    <= stk_wr_d;
            stk_wdata_q <= stk_wdata_d;
        end
    end

    // indirect jump and call, target from the address register
    always_comb begin
        pc_load_d   = 1'b0;
        pc_call_d   = 1'b0;
        pc_target_d = pc_target_q;                // target holds between uses
        // both branch kinds take the masked register
        if (cur_op == CSR_OP_JUMP) begin
            pc_load_d   = 1'b1;
            pc_target_d = ar_q & AR_MASK;
        end
        if (cur_op == CSR_OP_CALL) begin
            pc_call_d   = 1'b1;
            pc_target_d = ar_q & AR_MASK;
        end
    end

    // program counter request registers
    always_ff @(posedge clk) begin
        if (reset) begin
            pc_load_q   <= 1'b0;
            pc_call_q   <= 1'b0;
            pc_target_q <= CSR_AR_RESET;
        end else begin
            pc_load_q   <= pc_load_d;
            pc_call_q   <= pc_call_d;
            pc_target_q <= pc_target_d;
        end
    end

    // table read address and buffer transfers
    always_comb begin
        rom_rd_d     = 1'b0;
        rom_addr_d   = rom_addr_q;                // address holds after fetch
        tbuf_wr_d    = 1'b0;
        tbuf_wdata_d = tbuf_wdata_q;              // word holds after write
        if (cur_op == CSR_OP_TBL_1ST) begin
            rom_rd_d   = 1'b1;
            rom_addr_d = ar_q & AR_MASK;
        end
        if (cur_op == CSR_OP_BUF_FETCH) begin
            tbuf_wr_d    = 1'b1;
            tbuf_wdata_d = ar_q & AR_MASK;
        end
        // a pending table word wins over a fetch
        if (tbl_q) begin
            // rom word arrives in the same cycle as the registered address
            tbuf_wr_d    = 1'b1;
            tbuf_wdata_d = rom_data;
        end
    end

    // program memory and table buffer registers
    always_ff @(posedge clk) begin
        if (reset) begin
            rom_rd_q     <= 1'b0;
            rom_addr_q   <= CSR_AR_RESET;
            tbuf_wr_q    <= 1'b0;
            tbuf_wdata_q <= CSR_AR_RESET;
        end else begin
            rom_rd_q     <= rom_rd_d;
            rom_addr_q   <= rom_addr_d;
            tbuf_wr_q    <= tbuf_wr_d;
            tbuf_wdata_q <= tbuf_wdata_d;
        end
    end

    // peripheral file transfers through the window
    always_comb begin
        pf_wr_d    = 1'b0;
        pf_addr_d  = pf_addr_q;                   // address holds between uses
        pf_wdata_d = pf_wdata_q;
        // read and write share one address register
        if (cur_op == CSR_OP_FILE_RD) begin
            pf_addr_d = op_file_addr;
        end
        if (cur_op == CSR_OP_FILE_WR) begin
            pf_wr_d    = 1'b1;
            pf_addr_d  = op_file_addr;
            pf_wdata_d = win_q;
        end
    end

    // peripheral file request registers
    always_ff @(posedge clk) begin
        if (reset) begin
            pf_wr_q    <= 1'b0;
            pf_addr_q  <= '0;
            pf_wdata_q <= CSR_NIB_ZERO;
        end else begin
            pf_wr_q    <= pf_wr_d;
            pf_addr_q  <= pf_addr_d;
            pf_wdata_q <= pf_wdata_d;
        end
    end

    // window keeps its value through any reset
    always_ff @(posedge clk) begin
        win_q <= win_d;
    end

    // outputs straight from flip-flops
    assign dm_rdata   = dm_rdata_q;
    assign dm_hit     = dm_hit_q;
    assign stk_dec    = stk_dec_q;
    assign stk_inc    = stk_inc_q;
    assign stk_wr     = stk_wr_q;
    assign stk_wdata  = stk_wdata_q;
    assign pc_load    = pc_load_q;
    assign pc_call    = pc_call_q;
    assign pc_target  = pc_target_q;
    assign rom_rd     = rom_rd_q;
    assign rom_addr   = rom_addr_q;
    assign tbuf_wr    = tbuf_wr_q;
    assign tbuf_wdata = tbuf_wdata_q;
    assign pf_rd      = pf_rd_q;
    assign pf_wr      = pf_wr_q;
    assign pf_addr    = pf_addr_q;
    assign pf_wdata   = pf_wdata_q;
endmodule

// >>> csr_window_chk.sv
// checker: port-level assertions for the control space block
`timescale 1ns/1ps
module csr_window_chk
    import csr_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [6:0]  dm_addr,
    input wire logic        dm_rd,
    input wire logic [3:0]  dm_rdata,
    input wire logic        dm_hit,
    input wire logic [3:0]  op,
    input wire logic [6:0]  op_file_addr,
    input wire logic        stk_dec,
    input wire logic        stk_inc,
    input wire logic        stk_wr,
    input wire logic        pc_load,
    input wire logic        pc_call,
    input wire logic [15:0] pc_target,
    input wire logic        rom_rd,
    input wire logic [15:0] rom_data,
    input wire logic        tbuf_wr,
    input wire logic [15:0] tbuf_wdata,
    input wire logic        pf_rd,
    input wire logic        pf_wr,
    input wire logic [6:0]  pf_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // address lies in the control space
    wire in_sp = (dm_addr >= CSR_SPACE_LO) && (dm_addr <= CSR_SPACE_HI);
    // table read, both cycles back to back
    sequence tbl_seq;
        op == CSR_OP_TBL_1ST ##1 op == CSR_OP_TBL_2ND;
    endsequence
    // buffer fetch straight before a jump
    sequence fetch_jump_seq;
        op == CSR_OP_BUF_FETCH ##1 op == CSR_OP_JUMP;
    endsequence
    hit_decode_a: assert property (dm_rd && in_sp |=> dm_hit)
        else $error("control read not flagged");
    miss_decode_a: assert property (dm_rd && !in_sp
        |=> !dm_hit && dm_rdata == 4'h0) else $error("stray read answered");
    reset_clear_a: assert property ($fell(reset)
        |-> pc_target == 16'h0 && !tbuf_wr) else $error("reset not clean");
    push_pair_a: assert property (op == CSR_OP_PUSH
        |=> stk_dec && stk_wr) else $error("push strobes missing");
    pop_inc_a: assert property (op == CSR_OP_POP
        |=> stk_inc && !stk_wr) else $error("pop strobes wrong");
    jump_load_a: assert property (op == CSR_OP_JUMP
        |=> pc_load && !pc_call) else $error("jump strobe wrong");
    call_strobe_a: assert property (op == CSR_OP_CALL
        |=> pc_call && stk_dec) else $error("call strobes wrong");
    tbl_first_a: assert property (op == CSR_OP_TBL_1ST
        |=> rom_rd && stk_dec) else $error("table fetch missing");
    tbl_done_a: assert property (tbl_seq
        |=> tbuf_wr && stk_inc && tbuf_wdata == $past(rom_data))
        else $error("table word not stored");
    jump_target_a: assert property (fetch_jump_seq
        |=> pc_target == $past(tbuf_wdata)) else $error("jump target bad");
    file_read_a: assert property (op == CSR_OP_FILE_RD
        |=> pf_rd && pf_addr == $past(op_file_addr))
        else $error("file read wrong");
    file_write_a: assert property (op == CSR_OP_FILE_WR
        |=> pf_wr && pf_addr == $past(op_file_addr))
        else $error("file write wrong");
endmodule

bind csr_window csr_window_chk u_chk (
    .clk(clk), .reset(reset), .dm_addr(dm_addr), .dm_rd(dm_rd),
    .dm_rdata(dm_rdata), .dm_hit(dm_hit), .op(op),
    .op_file_addr(op_file_addr), .stk_dec(stk_dec), .stk_inc(stk_inc),
    .stk_wr(stk_wr), .pc_load(pc_load), .pc_call(pc_call),
    .pc_target(pc_target), .rom_rd(rom_rd), .rom_data(rom_data),
    .tbuf_wr(tbuf_wr), .tbuf_wdata(tbuf_wdata), .pf_rd(pf_rd),
    .pf_wr(pf_wr), .pf_addr(pf_addr)
);

// >>> csr_far_model.sv
// far side model: stack, program memory, table buffer, peripheral file
`timescale 1ns/1ps
module csr_far_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        stk_dec,
    input  wire logic        stk_inc,
    input  wire logic        stk_wr,
    input  wire logic [15:0] stk_wdata,
    output logic      [2:0]  stack_index,
    output logic      [15:0] stk_rdata,
    input  wire logic        rom_rd,
    input  wire logic [15:0] rom_addr,
    output logic      [15:0] rom_data,
    input  wire logic        tbuf_wr,
    input  wire logic [15:0] tbuf_wdata,
    output logic      [15:0] table_buffer,
    input  wire logic        pf_rd,
    input  wire logic        pf_wr,
    input  wire logic [6:0]  pf_addr,
    input  wire logic [3:0]  pf_wdata,
    output logic      [3:0]  pf_rdata
);
    logic [15:0] stk [0:7];  // address stack entries
    logic [3:0]  pf [0:127]; // peripheral file
    logic [15:0] rom_q;      // last word fetched
    logic        rom_v;      // word still held
    logic [3:0]  pf_q;       // last file nibble
    logic [2:0]  nxt;        // index after this cycle
    // index moves first so a push lands in the fresh entry
    assign nxt = stack_index - {2'b0, stk_dec} + {2'b0, stk_inc};
    // stack, buffer and file updates
    always @(posedge clk) begin
        stack_index <= reset ? 3'h5 : nxt;
        if (stk_wr) stk[nxt] <= stk_wdata;
        if (tbuf_wr) table_buffer <= tbuf_wdata;
        if (pf_wr) pf[pf_addr] <= pf_wdata;
        if (rom_rd) rom_q <= rom_addr ^ 16'hc35a;
        rom_v <= rom_rd;
        if (pf_rd) pf_q <= pf[pf_addr];
    end
    // read sides; released lines show the inverse of the last value, except rom_data holds rom_q for the cycle after a fetch
    assign stk_rdata = stk[stack_index];
    assign rom_data = rom_rd ? rom_addr ^ 16'hc35a
                             : (rom_v ? rom_q : ~rom_q);
    assign pf_rdata = pf_rd ? pf[pf_addr] : ~pf_q;
endmodule

// >>> csr_window_tb_top.sv
// testbench: nibble access, datapath operations, reset retention
`timescale 1ns/1ps
module csr_window_tb_top
    import csr_pkg::*;
;
    logic        clk = 0, reset = 1, dm_wr = 0, dm_rd = 0;
    logic [6:0]  dm_addr = 7'h0, op_file_addr = 7'h0, pf_addr;
    logic [3:0]  dm_wdata = 4'h0, op = 4'h0, dm_rdata, pf_wdata, pf_rdata;
    logic        dm_hit, stk_dec, stk_inc, stk_wr, pc_load, pc_call;
    logic        rom_rd, tbuf_wr, pf_rd, pf_wr;
    logic [2:0]  stack_index;
    logic [15:0] stk_wdata, stk_rdata, pc_target, rom_addr, rom_data;
    logic [15:0] table_buffer, tbuf_wdata;
    int          err_count = 0, compares = 0;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    csr_window #(.EFF_W(11)) uut (
        .clk(clk), .reset(reset), .dm_addr(dm_addr), .dm_wr(dm_wr),
        .dm_wdata(dm_wdata), .dm_rd(dm_rd), .dm_rdata(dm_rdata),
        .dm_hit(dm_hit), .op(op), .op_file_addr(op_file_addr),
        .stack_index(stack_index), .stk_dec(stk_dec), .stk_inc(stk_inc),
        .stk_wr(stk_wr), .stk_wdata(stk_wdata), .stk_rdata(stk_rdata),
        .pc_load(pc_load), .pc_call(pc_call), .pc_target(pc_target),
        .rom_rd(rom_rd), .rom_addr(rom_addr), .rom_data(rom_data),
        .table_buffer(table_buffer), .tbuf_wr(tbuf_wr),
        .tbuf_wdata(tbuf_wdata), .pf_rd(pf_rd), .pf_wr(pf_wr),
        .pf_addr(pf_addr), .pf_wdata(pf_wdata), .pf_rdata(pf_rdata));
    csr_far_model u_far (
        .clk(clk), .reset(reset), .stk_dec(stk_dec), .stk_inc(stk_inc),
        .stk_wr(stk_wr), .stk_wdata(stk_wdata), .stack_index(stack_index),
        .stk_rdata(stk_rdata), .rom_rd(rom_rd), .rom_addr(rom_addr),
        .rom_data(rom_data), .tbuf_wr(tbuf_wr), .tbuf_wdata(tbuf_wdata),
        .table_buffer(table_buffer), .pf_rd(pf_rd), .pf_wr(pf_wr),
        .pf_addr(pf_addr), .pf_wdata(pf_wdata), .pf_rdata(pf_rdata));
    // compare one value, count and report
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask
    // one-cycle nibble write
    task automatic wr(logic [6:0] a, logic [3:0] d);
        @(negedge clk);
        dm_wr = 1; dm_addr = a; dm_wdata = d;
        @(negedge clk);
        dm_wr = 0;
    endtask
    // nibble read, data and hit checked a cycle later
    task automatic rd(logic [6:0] a, logic [3:0] e, logic h);
        @(negedge clk);
        dm_rd = 1; dm_addr = a;
        @(negedge clk);
        dm_rd = 0;
        chk("rdata", {12'h0, e}, {12'h0, dm_rdata});
        chk("hit", {15'h0, h}, {15'h0, dm_hit});
    endtask
    // one operation, then settle time for two-edge answers
    task automatic opx(logic [3:0] o, logic [6:0] fa);
        @(negedge clk);
        op = o; op_file_addr = fa;
        @(negedge clk);
        op = CSR_OP_NONE;
        repeat (2) @(negedge clk);
    endtask
    // whole address register, most significant nibble first
    task automatic ar_set(logic [15:0] v);
        for (int i = 0; i < 4; i++) wr(7'h74 + 7'(i), v[15-4*i -: 4]);
    endtask
    task automatic ar_chk(logic [15:0] e);
        for (int i = 0; i < 4; i++) rd(7'h74 + 7'(i), e[15-4*i -: 4], 1);
    endtask
    // verdict and end of run
    task automatic close_out();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // run takes some 160 cycles; cut a hang at 2000
    initial begin
        #50000;
        err_count++;
        close_out();
    end
    initial begin
        repeat (4) @(negedge clk);
        reset = 0;
        ar_chk(16'h0000);
        ar_set(16'hffa5);
        ar_chk(16'h07a5);
        wr(7'h78, 4'hc);
        rd(7'h78, 4'hc, 1);
        rd(7'h79, 4'h0, 1);
        rd(7'h7f, 4'h0, 1);
        rd(7'h20, 4'h0, 0);
        @(negedge clk);
        op = CSR_OP_BUF_FETCH;
        @(negedge clk);
        op = CSR_OP_JUMP;
        @(negedge clk);
        op = CSR_OP_NONE;
        @(negedge clk);
        chk("buffer", 16'h07a5, table_buffer);
        chk("target", 16'h07a5, pc_target);
        ar_set(16'h0123);
        opx(CSR_OP_CALL, 7'h0);
        chk("target", 16'h0123, pc_target);
        @(negedge clk);
        op = CSR_OP_TBL_1ST;
        @(negedge clk);
        op = CSR_OP_TBL_2ND;
        @(negedge clk);
        op = CSR_OP_NONE;
        repeat (2) @(negedge clk);
        chk("buffer", 16'h0123 ^ 16'hc35a, table_buffer);
        chk("index", 16'h4, {13'h0, stack_index});
        opx(CSR_OP_PUSH, 7'h0);
        chk("index", 16'h3, {13'h0, stack_index});
        chk("entry", 16'h0123, u_far.stk[3]);
        ar_set(16'h0000);
        opx(CSR_OP_POP, 7'h0);
        ar_chk(16'h0123);
        chk("index", 16'h4, {13'h0, stack_index});
        ar_set(16'h07af);
        opx(CSR_OP_INC, 7'h0);
        ar_chk(16'h07b0);
        ar_set(16'h07ff);
        opx(CSR_OP_INC, 7'h0);
        ar_chk(16'h0000);
        u_far.table_buffer = 16'hffff;
        opx(CSR_OP_BUF_LOAD, 7'h0);
        ar_chk(16'h07ff);
        u_far.pf[7'h21] = 4'h9;
        opx(CSR_OP_FILE_RD, 7'h21);
        rd(7'h78, 4'h9, 1);
        wr(7'h78, 4'h3);
        opx(CSR_OP_FILE_WR, 7'h22);
        chk("file", 16'h3, {12'h0, u_far.pf[7'h22]});
        reset = 1;
        repeat (4) @(negedge clk);
        reset = 0;
        rd(7'h78, 4'h3, 1);
        ar_chk(16'h0000);
        close_out();
    end
endmodule
